// ===== rtl/febs_pkg.sv
/*
 holds the register offsets, field positions, reset values and address
 constants of the erase-block select and RAM overlay logic.
 assumes a 24-bit CPU address and a plain register port with 8-bit data.
*/
package febs_pkg;
   // register offsets on the plain register port
   localparam logic [3:0] off_flash_control_one = 4'h0;
   localparam logic [3:0] off_erase_block_select_lo = 4'h2;
   localparam logic [3:0] off_erase_block_select_hi = 4'h3;
   localparam logic [3:0] off_ram_overlay_control = 4'h4;
   localparam logic [3:0] off_protect_status = 4'h5;

   // reset values
   localparam logic [7:0] rst_flash_control_one = 8'h00;
   localparam logic [7:0] rst_erase_block_select = 8'h00;
   localparam logic [7:0] rst_ram_overlay_control = 8'h00;

   // edges the mode synchroniser needs before its output holds the straps
   localparam logic [1:0] mode_settle_cycles = 2'h2;

   // field positions
   localparam int pos_flash_write_unlock = 6;
   localparam int pos_overlay_select = 3;
   localparam int pos_overlay_reserved = 4;
   localparam logic [7:0] hi_writable_mask = 8'hff;
   localparam logic [7:0] overlay_writable_mask = 8'h1f;

   // address map
   localparam logic [23:0] flash_base_low_modes = 24'h000000;
   localparam logic [23:0] flash_base_high_modes = 24'h100000;
   localparam logic [23:0] block_eight_offset = 24'h008000;
   localparam logic [23:0] block_eight_last = 24'h00ffff;
   localparam logic [23:0] flash_last_offset = 24'h05ffff;
   localparam logic [23:0] ram_window_base = 24'hffb000;
   localparam int small_block_shift = 12;
   localparam int large_block_shift = 16;
   localparam int block_count = 14;

   // operating modes from the mode pins
   localparam logic [2:0] mode_three = 3'h3;
   localparam logic [2:0] mode_four = 3'h4;
   localparam logic [2:0] mode_five = 3'h5;
   localparam logic [2:0] mode_six = 3'h6;
   localparam logic [2:0] mode_seven = 3'h7;
endpackage

// ===== rtl/febs_remap_if.sv
/*
 carries the overlay settings from the register logic to the address remap.
 assumes both ends share one clock.
*/
`timescale 1ns/1ps
interface febs_remap_if;
   logic overlay_on;
   logic [2:0] overlay_area;
   logic high_base;
   modport regs (output overlay_on, output overlay_area, output high_base);
   modport remap (input overlay_on, input overlay_area, input high_base);
endinterface

// ===== rtl/febs_remap.sv
/*
 address remap: decodes the erase block of a CPU address and redirects
 the selected 4-kbyte flash block into a fixed RAM window.
 assumes settings come from the register logic on the same clock.
*/
`timescale 1ns/1ps
module febs_remap (
   input wire logic clock,
   input wire logic rst,
   febs_remap_if.remap cfg,
   input wire logic [23:0] cpu_addr,
   output logic [23:0] mapped_addr_ff,
   output logic to_ram_ff,
   output logic [13:0] addr_block_ff,
   output logic in_flash_ff
);
   logic [23:0] base;
   logic [23:0] offs;
   logic [23:0] ovl_start;
   logic in_range;
   logic [13:0] blk;
   logic hit;

   always_comb begin
      base = cfg.high_base ? febs_pkg::flash_base_high_modes
                           : febs_pkg::flash_base_low_modes;
      offs = cpu_addr - base;
      in_range = (cpu_addr >= base) && (offs <= febs_pkg::flash_last_offset);
      blk = '0;
      if (in_range) begin
         if (offs < febs_pkg::block_eight_offset) begin
            blk[offs[14:12]] = 1'b1; // RULE7
         end else if (offs <= febs_pkg::block_eight_last) begin
            blk[8] = 1'b1; // RULE8
         end else begin
            blk[4'(offs[19:16]) + 4'h8] = 1'b1; // RULE9
         end
      end
      ovl_start = base + {9'h000, cfg.overlay_area, 12'h000}; // RULE13 RULE18
      hit = cfg.overlay_on && in_range && (cpu_addr[23:12] == ovl_start[23:12]);
   end

   // registered so a new setting applies from the next access onward
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         mapped_addr_ff <= 24'h000000;
         to_ram_ff <= 1'b0;
         addr_block_ff <= 14'h0000;
         in_flash_ff <= 1'b0;
      end else begin
         to_ram_ff <= hit; // RULE10 RULE12 RULE20
         mapped_addr_ff <= hit ? {febs_pkg::ram_window_base[23:12], cpu_addr[11:0]}
                               : cpu_addr;
         addr_block_ff <= blk;
         in_flash_ff <= in_range && !hit;
      end
   end
endmodule

// ===== rtl/febs_top.sv
/*
 erase-block select registers, write-unlock control and RAM overlay control,
 with the address remap instantiated below.
 assumes a single-cycle register port and stable mode pins after reset.
*/
// The strobed register port and the register addresses were decided locally.
// Summary of operation
// RULE1 - upper select register reads zero while write unlock is clear
// RULE2 - more than one select bit set clears both select registers
// RULE3 - software sets at most one select bit overall
// RULE4 - upper bits five to one pick 64-kbyte blocks thirteen to nine
// RULE5 - upper bit zero picks the 32-kbyte block eight
// RULE6 - software keeps reserved bits at zero
// RULE7 - blocks zero to seven are 4-kbyte steps from mode base
// RULE8 - block eight at offset 8000 to ffff, then 64-kbyte blocks
// RULE9 - highest block ends at 05ffff or 15ffff by mode
// RULE10 - overlay select set redirects the chosen block into RAM
// RULE11 - overlay active protects every block from program and erase
// RULE12 - overlay select clear sends accesses to the flash array
// RULE13 - overlay area code n picks 4-kbyte block n
// RULE14 - overlay control bits seven to five read zero
// RULE15 - software avoids the emulated area right after the write
// RULE16 - software writes overlay control only in user modes
// RULE17 - select writes ignored while write unlock is clear
// RULE18 - in modes five and six overlay code zero maps 100000
// RULE19 - lower bit n picks 4-kbyte block n
// RULE20 - remap applies from the next access into a fixed RAM window
`timescale 1ns/1ps
module febs_top (
   input wire logic clock,
   input wire logic rst,
   input wire logic [2:0] mode_pins,
   input wire logic [3:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata_ff,
   input wire logic [23:0] cpu_addr,
   output logic [23:0] mapped_addr_ff,
   output logic to_ram_ff,
   output logic [13:0] erase_target,
   output logic [13:0] addr_block,
   output logic in_flash,
   output logic write_protect
);
   logic [2:0] mode_meta_ff;
   logic [2:0] mode_sync_ff;
   logic [2:0] mode_ff;
   logic mode_taken_ff;
   logic [1:0] mode_cnt_ff;
   logic [7:0] flash_control_one_ff;
   logic [7:0] erase_block_select_lo_ff;
   logic [7:0] erase_block_select_hi_ff;
   logic [7:0] ram_overlay_control_ff;
   logic [7:0] nxt_lo;
   logic [7:0] nxt_hi;
   logic [13:0] nxt_sel;
   logic unlock;
   logic wr_fc;
   logic wr_lo;
   logic wr_hi;
   logic wr_ovl;
   logic [7:0] rd_mux;

   febs_remap_if cfg_bus ();

   // mode pins are straps from outside: two flops, then caught once
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         mode_meta_ff <= 3'h0;
         mode_sync_ff <= 3'h0;
      end else begin
         mode_meta_ff <= mode_pins;
         mode_sync_ff <= mode_meta_ff;
      end
   end

   // the synchroniser shows its reset value for two edges; catching earlier locks mode zero
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         mode_ff <= 3'h0;
         mode_taken_ff <= 1'b0;
         mode_cnt_ff <= 2'h0;
      end else if (mode_cnt_ff != febs_pkg::mode_settle_cycles) begin
         mode_cnt_ff <= mode_cnt_ff + 2'h1;
      end else if (!mode_taken_ff) begin
         mode_ff <= mode_sync_ff;
         mode_taken_ff <= 1'b1;
      end
   end

   assign wr_fc = reg_wr && (reg_addr == febs_pkg::off_flash_control_one);
   assign wr_lo = reg_wr && (reg_addr == febs_pkg::off_erase_block_select_lo);
   assign wr_hi = reg_wr && (reg_addr == febs_pkg::off_erase_block_select_hi);
   assign wr_ovl = reg_wr && (reg_addr == febs_pkg::off_ram_overlay_control);
   assign unlock = flash_control_one_ff[febs_pkg::pos_flash_write_unlock];

   // only the write-unlock bit is kept; sequencing bits are not modelled here
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         flash_control_one_ff <= febs_pkg::rst_flash_control_one;
      end else if (wr_fc) begin
         flash_control_one_ff <= reg_wdata & (8'h01 << febs_pkg::pos_flash_write_unlock);
      end
   end

   always_comb begin
      nxt_lo = erase_block_select_lo_ff;
      nxt_hi = erase_block_select_hi_ff;
      if (wr_lo) begin
         nxt_lo = reg_wdata;
      end
      if (wr_hi) begin
         nxt_hi = reg_wdata & febs_pkg::hi_writable_mask;
      end
      nxt_sel = {nxt_hi[5:0], nxt_lo};
      if (!unlock || (wr_fc && !reg_wdata[febs_pkg::pos_flash_write_unlock])) begin
         nxt_lo = febs_pkg::rst_erase_block_select; // RULE17
         nxt_hi = febs_pkg::rst_erase_block_select; // RULE1
      end else if (!$onehot0({nxt_hi[7:6], nxt_sel})) begin
         nxt_lo = febs_pkg::rst_erase_block_select; // RULE2
         nxt_hi = febs_pkg::rst_erase_block_select; // RULE2
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         erase_block_select_lo_ff <= febs_pkg::rst_erase_block_select;
         erase_block_select_hi_ff <= febs_pkg::rst_erase_block_select;
      end else begin
         erase_block_select_lo_ff <= nxt_lo;
         erase_block_select_hi_ff <= nxt_hi;
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         ram_overlay_control_ff <= febs_pkg::rst_ram_overlay_control;
      end else if (wr_ovl) begin
         ram_overlay_control_ff <= reg_wdata & febs_pkg::overlay_writable_mask; // RULE14
      end
   end

   // one-hot erase target: bit n is block n
   assign erase_target = {erase_block_select_hi_ff[5:1], // RULE4
                          erase_block_select_hi_ff[0], // RULE5
                          erase_block_select_lo_ff}; // RULE19
   assign write_protect = ram_overlay_control_ff[febs_pkg::pos_overlay_select]; // RULE11

   assign cfg_bus.overlay_on = ram_overlay_control_ff[febs_pkg::pos_overlay_select];
   assign cfg_bus.overlay_area = ram_overlay_control_ff[2:0];
   assign cfg_bus.high_base = (mode_ff == febs_pkg::mode_five) ||
                              (mode_ff == febs_pkg::mode_six); // RULE18

   febs_remap u_remap (
      .clock(clock),
      .rst(rst),
      .cfg(cfg_bus),
      .cpu_addr(cpu_addr),
      .mapped_addr_ff(mapped_addr_ff),
      .to_ram_ff(to_ram_ff),
      .addr_block_ff(addr_block),
      .in_flash_ff(in_flash)
   );

   always_comb begin
      unique case (reg_addr)
         febs_pkg::off_flash_control_one: rd_mux = flash_control_one_ff;
         febs_pkg::off_erase_block_select_lo: rd_mux = erase_block_select_lo_ff;
         febs_pkg::off_erase_block_select_hi: rd_mux = erase_block_select_hi_ff;
         febs_pkg::off_ram_overlay_control: rd_mux = ram_overlay_control_ff;
         febs_pkg::off_protect_status: rd_mux = {7'h00, write_protect};
         default: rd_mux = 8'h00;
      endcase
   end

   // read data valid only in the cycle after the strobe
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         reg_rdata_ff <= 8'h00;
      end else begin
         reg_rdata_ff <= reg_rd ? rd_mux : 8'h00;
      end
   end
endmodule

// ===== dv/febs_top_props.sv
/* checker for the febs_top ports.
 assumes one clock and an asynchronous active-high reset. */
`timescale 1ns/1ps
module febs_top_props (
   input wire logic clock,
   input wire logic rst,
   input wire logic [3:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata_ff,
   input wire logic [23:0] cpu_addr,
   input wire logic [23:0] mapped_addr_ff,
   input wire logic to_ram_ff,
   input wire logic [13:0] erase_target,
   input wire logic [13:0] addr_block,
   input wire logic write_protect
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);
   sequence s_lock; reg_wr && reg_addr == 4'h0 && !reg_wdata[6]; endsequence
   sequence s_hi_wr; reg_wr && reg_addr == 4'h3; endsequence
   property p_one_sel; $onehot0(erase_target); endproperty
   property p_lock_clear; s_lock |=> erase_target == 14'h0; endproperty
   property p_lock_hold;
      s_lock ##1 !(reg_wr && reg_addr == 4'h0) ##1 s_hi_wr |=> erase_target == 14'h0;
   endproperty
   property p_protect; reg_wr && reg_addr == 4'h4 |=> write_protect == $past(reg_wdata[3]);
   endproperty
   property p_ovl_read; reg_rd && reg_addr == 4'h4 |=> reg_rdata_ff[7:5] == 3'h0; endproperty
   property p_ram_sel; to_ram_ff |-> $past(write_protect); endproperty
   property p_mapped;
      to_ram_ff |-> mapped_addr_ff == {febs_pkg::ram_window_base[23:12], $past(cpu_addr[11:0])};
   endproperty
   property p_blk; $onehot0(addr_block); endproperty
   a_one_sel: assert property (p_one_sel) else $error("several erase blocks");
   a_lock_clear: assert property (p_lock_clear) else $error("select kept");
   a_lock_hold: assert property (p_lock_hold) else $error("locked write taken");
   a_protect: assert property (p_protect) else $error("protect wrong");
   a_ovl_read: assert property (p_ovl_read) else $error("high bits set");
   a_ram_sel: assert property (p_ram_sel) else $error("ram without select");
   a_mapped: assert property (p_mapped) else $error("ram address wrong");
   a_blk: assert property (p_blk) else $error("several blocks hit");
endmodule
bind febs_top febs_top_props i_props (.clock(clock), .rst(rst), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff),
   .cpu_addr(cpu_addr), .mapped_addr_ff(mapped_addr_ff), .to_ram_ff(to_ram_ff),
   .erase_target(erase_target), .addr_block(addr_block), .write_protect(write_protect));

// ===== dv/febs_top_tb.sv
/* testbench for febs_top: register and remap tests.
 assumes the bind of the checker is compiled alongside. */
`timescale 1ns/1ps
module febs_top_tb;
   logic clock = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, to_ram_ff, in_flash, write_protect;
   logic [2:0] mode_pins = 3'h3;
   logic [3:0] reg_addr = 4'h0;
   logic [7:0] reg_wdata = 8'h00, reg_rdata_ff;
   logic [23:0] cpu_addr = 24'h0, mapped_addr_ff, base = 24'h0;
   logic [13:0] erase_target, addr_block;
   int err_total = 0, n_tests = 0;
   always #5 clock = ~clock;
   febs_top i_dut (.clock(clock), .rst(rst), .mode_pins(mode_pins), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff),
      .cpu_addr(cpu_addr), .mapped_addr_ff(mapped_addr_ff), .to_ram_ff(to_ram_ff),
      .erase_target(erase_target), .addr_block(addr_block), .in_flash(in_flash),
      .write_protect(write_protect));
   task ck(input logic [31:0] s, input logic [31:0] e);
      n_tests++;
      if (s !== e) begin
         err_total++;
         $display("MISMATCH t=%0t seen %h exp %h", $time, s, e);
      end
   endtask
   task wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clock);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clock);
      reg_wr <= 1'b0;
      #1;
   endtask
   task rd(input logic [3:0] a, input logic [7:0] e);
      @(posedge clock);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clock);
      reg_rd <= 1'b0;
      #1 ck(reg_rdata_ff, e);
   endtask
   task acc(input logic [23:0] a);
      @(posedge clock);
      cpu_addr <= a;
      @(posedge clock);
      #1;
   endtask
   task do_reset(input logic [2:0] m);
      @(posedge clock);
      rst <= 1'b1;
      mode_pins <= m;
      base <= (m == 3'h5 || m == 3'h6) ? 24'h100000 : 24'h000000;
      repeat (10) @(posedge clock);
      rst <= 1'b0;
      repeat (4) @(posedge clock);
   endtask
   // block start offsets; the next block's start less one is this block's end
   function automatic logic [23:0] blk_start(input int i);
      if (i < 8) return 24'(i << 12);
      if (i == 8) return 24'h008000;
      return 24'((i - 8) << 16);
   endfunction
   task map_check;
      for (int i = 0; i < 14; i++) begin
         acc(base + blk_start(i));
         ck({in_flash, addr_block}, {1'b1, 14'h1 << i});
         acc(base + blk_start(i + 1) - 24'h1);
         ck({in_flash, addr_block}, {1'b1, 14'h1 << i});
      end
      acc(base + 24'h060000);
      ck({in_flash, addr_block}, 32'h0);
   endtask
   task ovl_check;
      for (int c = 0; c < 8; c++) begin
         wr(4'h4, 8'h08 | c[7:0]);
         ck(write_protect, 1'b1);
         rd(4'h5, 8'h01);
         acc(base + 24'(c << 12) + 24'h123);
         ck({to_ram_ff, in_flash, mapped_addr_ff}, {2'b10, 24'hffb123});
         acc(base + 24'((c ^ 1) << 12));
         ck(to_ram_ff, 1'b0);
      end
      wr(4'h4, 8'h00);
      acc(base + 24'h7123);
      ck({to_ram_ff, in_flash, write_protect, mapped_addr_ff}, {3'b010, base + 24'h7123});
   endtask
   task print_verdict;
      $display("comparisons %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   initial begin
      do_reset(3'h3);
      for (int a = 0; a < 6; a++) rd(a[3:0], 8'h00);
      rd(4'hf, 8'h00);
      wr(4'h3, 8'h02);
      rd(4'h3, 8'h00);
      wr(4'h0, 8'h40);
      rd(4'h0, 8'h40);
      for (int i = 0; i < 6; i++) begin
         wr(4'h3, 8'h01 << i);
         ck(erase_target, 32'h100 << i);
      end
      rd(4'h3, 8'h20);
      wr(4'h3, 8'h00);
      for (int i = 0; i < 8; i++) begin
         wr(4'h2, 8'h01 << i);
         ck(erase_target, 32'h1 << i);
      end
      wr(4'h3, 8'h01);
      ck(erase_target, 32'h0);
      rd(4'h2, 8'h00);
      wr(4'h3, 8'h10);
      wr(4'h0, 8'h00);
      ck(erase_target, 32'h0);
      wr(4'h3, 8'h02);
      rd(4'h3, 8'h00);
      wr(4'h4, 8'hef);
      rd(4'h4, 8'h0f);
      wr(4'h4, 8'h00);
      $display("register test done");
      map_check;
      ovl_check;
      $display("low base test done");
      do_reset(3'h5);
      map_check;
      ovl_check;
      $display("high base test done");
      do_reset(3'h6);
      map_check;
      ovl_check;
      $display("mode six test done");
      print_verdict;
   end
   initial begin
      #200000;
      err_total++;
      print_verdict;
   end
endmodule
